// ==== include/guard_consts.svh ====
`ifndef GUARD_CONSTS_SVH
`define GUARD_CONSTS_SVH

// ----------------------------------------------------------------
// unlock key register and key values
// ----------------------------------------------------------------
`define GUARD_KEY_ADDR 8'hC7
`define GUARD_KEY_FIRST 8'hAA
`define GUARD_KEY_SECOND 8'h55

// ----------------------------------------------------------------
// window length in memory cycles
// ----------------------------------------------------------------
`define GUARD_WINDOW_CYCLES 2'h3

// ----------------------------------------------------------------
// byte addresses of the guarded registers
// ----------------------------------------------------------------
`define GUARD_WDOG_ADDR 8'hD8
`define GUARD_EXINT_ADDR 8'hE1
`define GUARD_ADDRCTL_ADDR 8'hE2
`define GUARD_PROGSIZE_ADDR 8'hE3
`define GUARD_FLASH_ADDR 8'hE4

// ----------------------------------------------------------------
// protected lanes of each guarded register
// ----------------------------------------------------------------
`define GUARD_WDOG_PMASK 8'h4B
`define GUARD_EXINT_PMASK 8'h01
`define GUARD_ADDRCTL_PMASK 8'hE0
`define GUARD_PROGSIZE_PMASK 8'h0F
`define GUARD_FLASH_PMASK 8'h0F

// ----------------------------------------------------------------
// field positions inside the watchdog control register
// ----------------------------------------------------------------
`define GUARD_WDOG_RESTART_BIT 0
`define GUARD_WDOG_RESET_EN_BIT 1
`define GUARD_WDOG_IRQ_FLAG_BIT 3
`define GUARD_WDOG_POR_FLAG_BIT 6

// ----------------------------------------------------------------
// reset values of the protected bits
// ----------------------------------------------------------------
`define GUARD_WDOG_RESET 8'h00
`define GUARD_EXINT_RESET 8'h00
`define GUARD_ADDRCTL_RESET 8'h00
`define GUARD_PROGSIZE_RESET 8'h00
`define GUARD_FLASH_RESET 8'h00

`endif

// ==== include/guard_pkg.sv ====
package guard_pkg;

  // ----------------------------------------------------------------
  // unlock sequence states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_LOCKED,
    ST_ARMED,
    ST_OPEN
  } guard_state_t;

endpackage

// ==== verilog/window_timer.sv ====
`timescale 1ns/1ps
`include "guard_consts.svh"

module window_timer (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // control
  input wire logic i_load,
  input wire logic i_tick,
  // status
  output logic [1:0] o_left,
  output logic o_live
);

  logic [1:0] left_q;

  // load restarts the count, each memory cycle spends one
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      left_q <= 2'h0;
    end else if (i_load) begin
      left_q <= `GUARD_WINDOW_CYCLES;
    end else if (i_tick && left_q != 2'h0) begin
      left_q <= left_q - 2'h1;
    end
  end

  assign o_left = left_q;
  assign o_live = (left_q != 2'h0);

endmodule

// ==== verilog/timed_access_write_guard.sv ====
`timescale 1ns/1ps
`include "guard_consts.svh"


module timed_access_write_guard (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // memory cycle strobe from the core
  input wire logic i_mem_cycle,
  // byte write from the core
  input wire logic i_sfr_wr,
  input wire logic [7:0] i_sfr_addr,
  input wire logic [7:0] i_sfr_wdata,
  // single-bit write from the core
  input wire logic i_bit_wr,
  input wire logic [7:0] i_bit_addr,
  input wire logic i_bit_value,
  // hardware flag events
  input wire logic i_wdog_flag_set,
  input wire logic i_por_flag_set,
  // lanes the core may store itself
  output logic [7:0] o_pass_mask,
  // guard status
  output logic o_window_open,
  output logic o_write_refused,
  // protected bit values
  output logic [7:0] o_wdog_bits,
  output logic [7:0] o_exint_bits,
  output logic [7:0] o_addrctl_bits,
  output logic [7:0] o_progsize_bits,
  output logic [7:0] o_flash_bits
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  guard_pkg::guard_state_t state_q;
  guard_pkg::guard_state_t state_d;
  logic eff_wr;
  logic [7:0] eff_addr;
  logic [7:0] eff_data;
  logic [7:0] eff_mask;
  logic key_wr;
  logic key_first;
  logic key_second;
  logic timer_load;
  logic [1:0] win_left;
  logic win_live;
  logic gate;
  logic [7:0] prot_mask;
  logic [7:0] lane_ok;
  logic [7:0] wdog_q;
  logic [7:0] wdog_d;
  logic [7:0] exint_q;
  logic [7:0] addrctl_q;
  logic [7:0] progsize_q;
  logic [7:0] flash_q;
  logic refused_q;

  // replace masked lanes of a stored byte
  function automatic logic [7:0] merge(input logic [7:0] old_v,
                                       input logic [7:0] new_v,
                                       input logic [7:0] mask);
    merge = (old_v & ~mask) | (new_v & mask);
  endfunction

  // ----------------------------------------------------------------
  // access decode
  // ----------------------------------------------------------------

  // bit writes become one-lane byte writes to the bit-addressable byte
  always_comb begin
    eff_wr = 1'b0;
    eff_addr = i_sfr_addr;
    eff_data = i_sfr_wdata;
    eff_mask = 8'h00;
    if (i_sfr_wr) begin
      eff_wr = 1'b1;
      eff_mask = 8'hFF;
    end else if (i_bit_wr && i_bit_addr[7]) begin
      eff_wr = 1'b1;
      eff_addr = {i_bit_addr[7:3], 3'h0};
      eff_mask = 8'h01 << i_bit_addr[2:0];
      eff_data = {8{i_bit_value}};
    end
  end

  // key writes are whole-byte writes to the unlock key register
  assign key_wr = i_sfr_wr && (i_sfr_addr == `GUARD_KEY_ADDR);
  assign key_first = key_wr && (i_sfr_wdata == `GUARD_KEY_FIRST);
  assign key_second = key_wr && (i_sfr_wdata == `GUARD_KEY_SECOND);

  // protected lanes of the addressed register
  always_comb begin
    case (eff_addr)
      `GUARD_WDOG_ADDR: prot_mask = `GUARD_WDOG_PMASK;
      `GUARD_EXINT_ADDR: prot_mask = `GUARD_EXINT_PMASK;
      `GUARD_ADDRCTL_ADDR: prot_mask = `GUARD_ADDRCTL_PMASK;
      `GUARD_PROGSIZE_ADDR: prot_mask = `GUARD_PROGSIZE_PMASK;
      `GUARD_FLASH_ADDR: prot_mask = `GUARD_FLASH_PMASK;
      default: prot_mask = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // unlock sequence
  // ----------------------------------------------------------------

  // one timer serves both the arming and the open phase
  window_timer u_timer (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_load(timer_load),
    .i_tick(i_mem_cycle),
    .o_left(win_left),
    .o_live(win_live)
  );

  // next state of the unlock sequence
  always_comb begin
    state_d = state_q;
    timer_load = 1'b0;
    case (state_q)
      guard_pkg::ST_LOCKED: begin
        if (key_first) begin
          state_d = guard_pkg::ST_ARMED;
          timer_load = 1'b1;
        end
      end
      guard_pkg::ST_ARMED: begin
        if (key_second && win_live) begin
          state_d = guard_pkg::ST_OPEN;
          timer_load = 1'b1;
        end else if (key_first) begin
          timer_load = 1'b1;
        end else if (eff_wr || !win_live) begin
          state_d = guard_pkg::ST_LOCKED;
        end
      end
      guard_pkg::ST_OPEN: begin
        if (key_first) begin
          state_d = guard_pkg::ST_ARMED;
          timer_load = 1'b1;
        end else if (key_wr) begin
          state_d = guard_pkg::ST_LOCKED;
        end else if (!win_live) begin
          state_d = guard_pkg::ST_LOCKED;
        end
      end
      default: begin
        state_d = guard_pkg::ST_LOCKED;
      end
    endcase
  end

  // sequence state register
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q <= guard_pkg::ST_LOCKED;
    end else begin
      state_q <= state_d;
    end
  end

  // window stays open only while cycles remain
  assign gate = (state_q == guard_pkg::ST_OPEN) && win_live;
  assign lane_ok = gate ? eff_mask : 8'h00;

  // ----------------------------------------------------------------
  // protected storage
  // ----------------------------------------------------------------

  // watchdog bits: restart self-clears, hardware flag set beats clear
  always_comb begin
    wdog_d = wdog_q;
    wdog_d[`GUARD_WDOG_RESTART_BIT] = 1'b0;
    if (eff_wr && eff_addr == `GUARD_WDOG_ADDR) begin
      wdog_d = merge(wdog_q, eff_data, lane_ok & `GUARD_WDOG_PMASK);
    end
    if (i_wdog_flag_set) begin
      wdog_d[`GUARD_WDOG_IRQ_FLAG_BIT] = 1'b1;
    end
    if (i_por_flag_set) begin
      wdog_d[`GUARD_WDOG_POR_FLAG_BIT] = 1'b1;
    end
  end

  // watchdog register
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wdog_q <= `GUARD_WDOG_RESET;
    end else begin
      wdog_q <= wdog_d & `GUARD_WDOG_PMASK;
    end
  end

  // bandgap select
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      exint_q <= `GUARD_EXINT_RESET;
    end else if (eff_wr && eff_addr == `GUARD_EXINT_ADDR) begin
      exint_q <= merge(exint_q, eff_data,
                       lane_ok & `GUARD_EXINT_PMASK);
    end
  end

  // page mode controls
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      addrctl_q <= `GUARD_ADDRCTL_RESET;
    end else if (eff_wr && eff_addr == `GUARD_ADDRCTL_ADDR) begin
      addrctl_q <= merge(addrctl_q, eff_data,
                         lane_ok & `GUARD_ADDRCTL_PMASK);
    end
  end

  // program size and program ram enable
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      progsize_q <= `GUARD_PROGSIZE_RESET;
    end else if (eff_wr && eff_addr == `GUARD_PROGSIZE_ADDR) begin
      progsize_q <= merge(progsize_q, eff_data,
                          lane_ok & `GUARD_PROGSIZE_PMASK);
    end
  end

  // flash command bits
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      flash_q <= `GUARD_FLASH_RESET;
    end else if (eff_wr && eff_addr == `GUARD_FLASH_ADDR) begin
      flash_q <= merge(flash_q, eff_data,
                       lane_ok & `GUARD_FLASH_PMASK);
    end
  end

  // one-cycle flag for a protected lane that was refused
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      refused_q <= 1'b0;
    end else begin
      refused_q <= eff_wr && !gate && ((eff_mask & prot_mask) != 8'h00);
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------

  // unguarded lanes pass to the core's own storage, except on key writes
  assign o_pass_mask = (eff_wr && !key_wr) ?
                       (eff_mask & ~prot_mask) : 8'h00;
  assign o_window_open = gate;
  assign o_write_refused = refused_q;
  assign o_wdog_bits = wdog_q;
  assign o_exint_bits = exint_q;
  assign o_addrctl_bits = addrctl_q;
  assign o_progsize_bits = progsize_q;
  assign o_flash_bits = flash_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  sequence s_second_ok;
    state_q == guard_pkg::ST_ARMED && win_live && key_second;
  endsequence

  sequence s_open_full;
    state_q == guard_pkg::ST_OPEN && win_left == 2'h3 && gate;
  endsequence

  chk_unlock_opens: assert property (
    s_second_ok |=> s_open_full)
    else $error("window did not open after second key");

  chk_late_second: assert property (
    state_q == guard_pkg::ST_ARMED && !win_live && !key_first
    |=> state_q == guard_pkg::ST_LOCKED && !gate)
    else $error("late second key was not refused");

  chk_window_ends: assert property (
    state_q == guard_pkg::ST_OPEN && win_left == 2'h1 && i_mem_cycle
    && !key_wr |=> !gate ##1 state_q != guard_pkg::ST_OPEN)
    else $error("window outlived three memory cycles");

  chk_closed_keeps: assert property (
    !gate && eff_wr && eff_addr == `GUARD_ADDRCTL_ADDR
    |=> $stable(addrctl_q))
    else $error("protected bits changed while locked");

  chk_open_writes: assert property (
    gate && eff_wr && eff_addr == `GUARD_PROGSIZE_ADDR
    |=> progsize_q == ((($past(progsize_q) & ~$past(eff_mask))
         | ($past(eff_data) & $past(eff_mask))) & `GUARD_PROGSIZE_PMASK))
    else $error("open window write not applied");

  chk_free_lanes: assert property (
    eff_wr && !key_wr && prot_mask == 8'h00 |-> o_pass_mask == eff_mask)
    else $error("unguarded lanes were blocked");

  chk_bit_blocked: assert property (
    i_bit_wr && !i_sfr_wr && i_bit_addr == (`GUARD_WDOG_ADDR | 8'h01)
    && !gate |-> !o_pass_mask[1] ##1 $stable(wdog_q[1]) && refused_q)
    else $error("single-bit write slipped past the guard");

  chk_bad_key: assert property (
    key_wr && !key_first && !(state_q == guard_pkg::ST_ARMED && win_live
    && key_second) |=> state_q == guard_pkg::ST_LOCKED)
    else $error("wrong key value did not lock");

  chk_step_missed: assert property (
    state_q == guard_pkg::ST_ARMED && eff_wr && !key_wr
    |=> state_q == guard_pkg::ST_LOCKED ##1 state_q != guard_pkg::ST_OPEN)
    else $error("broken sequence did not lock");

  chk_spent_write: assert property (
    state_q == guard_pkg::ST_OPEN && win_left == 2'h0 && eff_wr
    && eff_addr == `GUARD_FLASH_ADDR |=> $stable(flash_q))
    else $error("write after spent window was applied");

endmodule

// ==== bench/core_model.sv ====
`timescale 1ns/1ps
`include "guard_consts.svh"

// ----------------------------------------------------------------
// processor core model issuing register writes
// ----------------------------------------------------------------
module core_model (
  // clock
  input wire logic i_clk,
  // byte and bit writes
  output logic o_sfr_wr,
  output logic [7:0] o_sfr_addr,
  output logic [7:0] o_sfr_wdata,
  output logic o_bit_wr,
  output logic [7:0] o_bit_addr,
  output logic o_bit_value
);
  // quiet bus at time zero
  initial begin
    o_sfr_wr = 1'b0;
    o_bit_wr = 1'b0;
    o_sfr_addr = 8'h00;
    o_sfr_wdata = 8'h00;
    o_bit_addr = 8'h00;
    o_bit_value = 1'b0;
  end

  // byte write held for the coming cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_sfr_wr <= 1'b1;
    o_bit_wr <= 1'b0;
    o_sfr_addr <= a;
    o_sfr_wdata <= d;
  endtask

  // single-bit write held for the coming cycle
  task automatic bw(input logic [7:0] a, input logic v);
    @(posedge i_clk);
    o_sfr_wr <= 1'b0;
    o_bit_wr <= 1'b1;
    o_bit_addr <= a;
    o_bit_value <= v;
  endtask

  // idle cycle; released lines show inverted data
  task automatic nop();
    @(posedge i_clk);
    o_sfr_wr <= 1'b0;
    o_bit_wr <= 1'b0;
    o_sfr_addr <= ~o_sfr_addr;
    o_sfr_wdata <= ~o_sfr_wdata;
    o_bit_addr <= ~o_bit_addr;
  endtask

  // key pair, with g idle cycles between when slow
  task automatic unlock(input int g);
    wr(`GUARD_KEY_ADDR, `GUARD_KEY_FIRST);
    repeat (g) nop();
    wr(`GUARD_KEY_ADDR, `GUARD_KEY_SECOND);
  endtask
endmodule

// ==== bench/timed_access_write_guard_tb.sv ====
`timescale 1ns/1ps
`include "guard_consts.svh"

module timed_access_write_guard_tb;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic por_set = 1'b0;
  logic wdog_set = 1'b0;
  logic mem_cycle = 1'b1;
  logic sfr_wr, bit_wr, bit_value;
  logic [7:0] sfr_addr, sfr_wdata, bit_addr, pass_mask;
  logic window_open, refused;
  logic [7:0] wdog, exint, addrctl, progsize, flash;
  int failures = 0;
  int comparisons = 0;
  logic [7:0] reg_addr [5] = '{`GUARD_WDOG_ADDR, `GUARD_EXINT_ADDR,
    `GUARD_ADDRCTL_ADDR, `GUARD_PROGSIZE_ADDR, `GUARD_FLASH_ADDR};
  logic [7:0] reg_mask [5] = '{`GUARD_WDOG_PMASK, `GUARD_EXINT_PMASK,
    `GUARD_ADDRCTL_PMASK, `GUARD_PROGSIZE_PMASK, `GUARD_FLASH_PMASK};

  // 100 ns clock
  always #50 clk = ~clk;

  // core model and guard
  core_model u_core_model (.i_clk(clk), .o_sfr_wr(sfr_wr),
    .o_sfr_addr(sfr_addr), .o_sfr_wdata(sfr_wdata), .o_bit_wr(bit_wr),
    .o_bit_addr(bit_addr), .o_bit_value(bit_value));
  timed_access_write_guard u_timed_access_write_guard (.i_clk(clk),
    .i_rst(rst), .i_mem_cycle(mem_cycle), .i_sfr_wr(sfr_wr),
    .i_sfr_addr(sfr_addr), .i_sfr_wdata(sfr_wdata), .i_bit_wr(bit_wr),
    .i_bit_addr(bit_addr), .i_bit_value(bit_value),
    .i_wdog_flag_set(wdog_set), .i_por_flag_set(por_set),
    .o_pass_mask(pass_mask), .o_window_open(window_open),
    .o_write_refused(refused), .o_wdog_bits(wdog), .o_exint_bits(exint),
    .o_addrctl_bits(addrctl), .o_progsize_bits(progsize),
    .o_flash_bits(flash));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] bits_of(input int i);
    case (i)
      0: bits_of = wdog;
      1: bits_of = exint;
      2: bits_of = addrctl;
      3: bits_of = progsize;
      default: bits_of = flash;
    endcase
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic settle();
    @(negedge clk);
  endtask

  task automatic do_reset();
    u_core_model.nop();
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
  endtask

  task automatic end_sim();
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic keys3(input logic [7:0] a0, d0, a1, d1, d2,
                       input logic exp);
    do_reset();
    u_core_model.wr(a0, d0);
    u_core_model.wr(a1, d1);
    u_core_model.wr(`GUARD_KEY_ADDR, d2);
    u_core_model.nop();
    settle();
    chk(window_open, exp);
  endtask

  task automatic s_keys();
    for (int g = 0; g < 4; g++) begin
      do_reset();
      u_core_model.unlock(g);
      u_core_model.nop();
      settle();
      chk(window_open, g < 3);
    end
    keys3(8'hC7, 8'hAA, 8'hC7, 8'h12, 8'h55, 1'b0);
    keys3(8'hC7, 8'hAA, 8'h90, 8'h00, 8'h55, 1'b0);
    keys3(8'h90, 8'h00, 8'h91, 8'h00, 8'h55, 1'b0);
    keys3(8'hC7, 8'hAA, 8'hC7, 8'hAA, 8'h55, 1'b1);
    keys3(8'hC7, 8'h12, 8'hC7, 8'hAA, 8'h55, 1'b1);
  endtask

  task automatic s_gap();
    for (int g = 0; g < 4; g++) begin
      do_reset();
      u_core_model.unlock(0);
      repeat (g) u_core_model.nop();
      u_core_model.wr(`GUARD_ADDRCTL_ADDR, 8'hE0);
      settle();
      chk(window_open, g < 3);
      u_core_model.nop();
      settle();
      chk(addrctl, (g < 3) ? 8'hE0 : 8'h00);
      chk(refused, g >= 3);
    end
  endtask

  task automatic s_table();
    logic [7:0] d;
    do_reset();
    for (int i = 0; i < 5; i++) begin
      d = (i == 0) ? 8'hFE : 8'hFF;
      u_core_model.unlock(0);
      u_core_model.wr(reg_addr[i], d);
      settle();
      chk(pass_mask, ~reg_mask[i]);
      u_core_model.nop();
      settle();
      chk(bits_of(i), reg_mask[i] & d);
      repeat (2) u_core_model.nop();
      u_core_model.wr(reg_addr[i], 8'h00);
      u_core_model.nop();
      settle();
      chk(refused, 1'b1);
      chk(bits_of(i), reg_mask[i] & d);
    end
    u_core_model.wr(8'h90, 8'h5A);
    settle();
    chk(pass_mask, 8'hFF);
    u_core_model.nop();
    settle();
    chk(refused, 1'b0);
  endtask

  task automatic s_second();
    do_reset();
    u_core_model.unlock(0);
    u_core_model.wr(`GUARD_FLASH_ADDR, 8'h05);
    u_core_model.wr(`GUARD_FLASH_ADDR, 8'h0A);
    u_core_model.nop();
    u_core_model.wr(`GUARD_FLASH_ADDR, 8'h03);
    u_core_model.nop();
    settle();
    chk(flash, 8'h0A);
    chk(refused, 1'b1);
  endtask

  task automatic s_bit();
    do_reset();
    u_core_model.unlock(0);
    u_core_model.bw(8'hD9, 1'b1);
    u_core_model.nop();
    settle();
    chk(wdog, 8'h02);
    repeat (3) u_core_model.nop();
    u_core_model.bw(8'hD9, 1'b0);
    u_core_model.nop();
    settle();
    chk(wdog, 8'h02);
    chk(refused, 1'b1);
    u_core_model.bw(8'hDA, 1'b1);
    settle();
    chk(pass_mask, 8'h04);
  endtask

  task automatic s_flags();
    do_reset();
    @(posedge clk);
    por_set <= 1'b1;
    @(posedge clk);
    por_set <= 1'b0;
    wdog_set <= 1'b1;
    @(posedge clk);
    wdog_set <= 1'b0;
    settle();
    chk(wdog, 8'h48);
    u_core_model.wr(`GUARD_WDOG_ADDR, 8'h00);
    u_core_model.nop();
    settle();
    chk(wdog, 8'h48);
    u_core_model.unlock(0);
    u_core_model.wr(`GUARD_WDOG_ADDR, 8'h00);
    wdog_set <= 1'b1;
    u_core_model.nop();
    wdog_set <= 1'b0;
    settle();
    chk(wdog, 8'h08);
  endtask

  // stalled memory cycles keep the window open until they resume
  task automatic s_stall();
    do_reset();
    mem_cycle <= 1'b0;
    u_core_model.unlock(0);
    repeat (4) u_core_model.nop();
    u_core_model.wr(`GUARD_ADDRCTL_ADDR, 8'h20);
    settle();
    chk(window_open, 1'b1);
    u_core_model.nop();
    mem_cycle <= 1'b1;
    settle();
    chk(addrctl, 8'h20);
    repeat (2) u_core_model.nop();
    settle();
    chk(window_open, 1'b1);
    u_core_model.nop();
    settle();
    chk(window_open, 1'b0);
  endtask

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    do_reset();
    settle();
    chk(window_open, 1'b0);
    for (int i = 0; i < 5; i++) chk(bits_of(i), 8'h00);
    s_keys();
    s_gap();
    s_table();
    s_second();
    s_bit();
    s_flags();
    s_stall();
    end_sim();
  end

  // cuts a hang short after about 20000 cycles
  initial begin
    #2000000;
    failures++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    end_sim();
  end
endmodule
